// ==== core/pdl_consts.svh ====
// Constants for the PLL divider and lock control block.
// Included by the package and design modules; definitions only.
`ifndef PDL_CONSTS_SVH
`define PDL_CONSTS_SVH

// APB register byte addresses
`define PDL_ADDR_CTRL 12'h000
`define PDL_ADDR_DIV 12'h004
`define PDL_ADDR_SKEW 12'h008
`define PDL_ADDR_STAT 12'h00C
`define PDL_ADDR_IRQ 12'h010
`define PDL_ADDR_MASK 12'h014

// CTRL fields
`define PDL_CTRL_BYPASS 0
`define PDL_CTRL_EXTFB 1
`define PDL_CTRL_COARSE 2
`define PDL_CTRL_FBSEL_LO 4
`define PDL_CTRL_FBSEL_HI 5
`define PDL_CTRL_LCNT_LO 8
`define PDL_CTRL_LCNT_HI 15

// DIV fields: exponent k at bits [4k+2:4k]
`define PDL_DIV_W 3
`define PDL_DIV_STRIDE 4
`define PDL_EXP_MAX 3'h5

// SKEW fields: setting k at bits [4k+2:4k]
`define PDL_SKEW_W 3
`define PDL_SKEW_STRIDE 4
`define PDL_SKEW_STEPS 8

// Lock count bounds, stored as count-1
`define PDL_LCNT_MIN 9'h010
`define PDL_LCNT_MAX 9'h100
`define PDL_LCNT_RST 8'h0F

// Interrupt status bits
`define PDL_IRQ_LOCK 0
`define PDL_IRQ_UNLOCK 1
`define PDL_IRQ_W 2

`endif

// ==== core/pdl_divider.sv ====
// Power-of-two clock divider driven by a sampled input clock level.
// Assumes the source level is already synchronous to clk_i.
`timescale 1ns/1ps
`include "pdl_consts.svh"

module pdl_divider #(
	parameter int CNT_W = 5
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Control
	input wire logic [`PDL_DIV_W-1:0] exp_i,
	input wire logic invert_i,
	// Clock level in and out
	input wire logic src_i,
	output logic div_o
);

	logic src_q;
	logic [CNT_W-1:0] cnt;
	logic div_q;
	logic [CNT_W-1:0] half;
	logic rise;

	assign rise = src_i & ~src_q;
	// Half ratio minus one, in source edges
	assign half = (exp_i == 3'h0) ? '0 : CNT_W'((1 << (exp_i - 3'h1)) - 1);

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			src_q <= 1'b0;
		else
			src_q <= src_i;
	end

	// Toggle every ratio/2 source cycles
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			cnt <= '0;
			div_q <= 1'b0;
		end
		else if (rise)
		begin
			if (cnt >= half)
			begin
				cnt <= '0;
				div_q <= ~div_q;
			end
			else
				cnt <= cnt + CNT_W'(1);
		end
	end

	// Ratio one passes through, inverted on request
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			div_o <= 1'b0;
		else if (exp_i == 3'h0)
			div_o <= src_i ^ invert_i;
		else
			div_o <= div_q;
	end

endmodule : pdl_divider

// ==== core/pdl_pkg.sv ====
// Types shared by the PLL divider and lock control block.
// Includes pdl_consts.svh but writes its field widths as literals.
`include "pdl_consts.svh"

package pdl_pkg;

	typedef enum logic [1:0] {
		PDL_UNLOCKED,
		PDL_COUNTING,
		PDL_LOCKED
	} pdl_lock_e;

	typedef struct packed {
		logic [7:0] lock_cnt;
		logic [1:0] fb_sel;
		logic coarse;
		logic ext_fb;
		logic bypass;
	} pdl_ctrl_s;

	typedef struct packed {
		logic [2:0] clk_o;
		logic fb_o;
		logic lock_o;
	} pdl_out_s;

endpackage : pdl_pkg

// ==== core/pdl_skew.sv ====
// Skew stage: delays a clock level by a whole number of phase steps.
// Steps are counted in samples of the phase clock clk_i.
`timescale 1ns/1ps
`include "pdl_consts.svh"

module pdl_skew #(
	parameter int DEPTH = 15
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Control
	input wire logic [`PDL_SKEW_W-1:0] step_i,
	input wire logic coarse_i,
	input wire logic enable_i,
	// Clock level in and out
	input wire logic src_i,
	output logic skew_o
);

	logic [DEPTH-1:0] line;
	logic [3:0] tap;

	// Coarse steps are twice the fine step
	assign tap = coarse_i ? {step_i, 1'b0} : {1'b0, step_i};

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			line <= '0;
		else
			line <= {line[DEPTH-2:0], src_i};
	end

	// Bypass when disabled or at zero
	always_comb
	begin
		if (!enable_i || tap == 4'h0)
			skew_o = src_i;
		else
			skew_o = line[tap-4'h1];
	end

endmodule : pdl_skew

// ==== core/pdl_top.sv ====
// PLL divider and lock control: lock detector, three dividers, skew.
// clk_i samples the VCO phase; ref_i and match_i are asynchronous.
`timescale 1ns/1ps
`include "pdl_consts.svh"

module pdl_top #(
	parameter int NUM_DIV = 3
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Clock side
	input wire logic ref_i,
	input wire logic vco_i,
	input wire logic match_i,
	input wire logic ext_fb_i,
	// Outputs
	output logic [NUM_DIV-1:0] clk_o,
	output logic fb_o,
	output logic lock_o,
	output logic irq_o
);

	pdl_pkg::pdl_ctrl_s ctrl;
	logic [31:0] div_reg;
	logic [31:0] skew_reg;
	logic [`PDL_IRQ_W-1:0] irq_stat;
	logic [`PDL_IRQ_W-1:0] irq_mask;
	pdl_pkg::pdl_lock_e lock_st;
	logic [8:0] lock_cnt;
	logic [1:0] ref_sync;
	logic [1:0] vco_sync;
	logic [1:0] match_sync;
	logic [1:0] efb_sync;
	logic ref_q;
	logic ref_rise;
	logic div_src;
	logic [NUM_DIV-1:0] div_out;
	logic [NUM_DIV-1:0] skew_out;
	logic skew_en;
	logic fb_int;
	logic lock_rise;
	logic lock_fall;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic [31:0] next_rdata;

	// Input synchronisers
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ref_sync <= 2'h0;
			vco_sync <= 2'h0;
			match_sync <= 2'h0;
			efb_sync <= 2'h0;
			ref_q <= 1'b0;
		end
		else
		begin
			ref_sync <= {ref_sync[0], ref_i};
			vco_sync <= {vco_sync[0], vco_i};
			match_sync <= {match_sync[0], match_i};
			efb_sync <= {efb_sync[0], ext_fb_i};
			ref_q <= ref_sync[1];
		end
	end

	assign ref_rise = ref_sync[1] & ~ref_q;

	// APB decode, zero wait states
	assign wr_en = psel_i & penable_i & pwrite_i;
	assign rd_en = psel_i & ~penable_i & ~pwrite_i;
	always_comb
	begin
		addr_ok = 1'b1;
		next_rdata = 32'h0000_0000;
		case (paddr_i)
			`PDL_ADDR_CTRL: next_rdata = {16'h0000, ctrl.lock_cnt, 2'h0, ctrl.fb_sel,
				1'b0, ctrl.coarse, ctrl.ext_fb, ctrl.bypass};
			`PDL_ADDR_DIV: next_rdata = div_reg;
			`PDL_ADDR_SKEW: next_rdata = skew_reg;
			`PDL_ADDR_STAT: next_rdata = {30'h0000_0000, lock_st == pdl_pkg::PDL_LOCKED, ctrl.bypass};
			`PDL_ADDR_IRQ: next_rdata = {30'h0000_0000, irq_stat};
			`PDL_ADDR_MASK: next_rdata = {30'h0000_0000, irq_mask};
			default: addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			prdata_o <= 32'h0000_0000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
		else
		begin
			pready_o <= psel_i & ~penable_i;
			pslverr_o <= psel_i & ~penable_i & ~addr_ok;
			if (rd_en)
				prdata_o <= next_rdata;
		end
	end

	// Control registers; exponents saturate at five
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ctrl <= '{lock_cnt: `PDL_LCNT_RST, fb_sel: 2'h0, coarse: 1'b0,
				ext_fb: 1'b0, bypass: 1'b0};
			div_reg <= 32'h0000_0000;
			skew_reg <= 32'h0000_0000;
			irq_mask <= '0;
		end
		else if (wr_en && pready_o)
		begin
			case (paddr_i)
				`PDL_ADDR_CTRL:
				begin
					ctrl.bypass <= pwdata_i[`PDL_CTRL_BYPASS];
					ctrl.ext_fb <= pwdata_i[`PDL_CTRL_EXTFB];
					ctrl.coarse <= pwdata_i[`PDL_CTRL_COARSE];
					// Feedback divider index 0..2
					ctrl.fb_sel <= (pwdata_i[`PDL_CTRL_FBSEL_HI:`PDL_CTRL_FBSEL_LO] > 2'h2)
						? 2'h2 : pwdata_i[`PDL_CTRL_FBSEL_HI:`PDL_CTRL_FBSEL_LO];
					// Counts below the floor are raised to it
					ctrl.lock_cnt <= ({1'b0, pwdata_i[`PDL_CTRL_LCNT_HI:`PDL_CTRL_LCNT_LO]}
						< `PDL_LCNT_MIN - 9'h001) ? 8'(`PDL_LCNT_MIN - 9'h001)
						: pwdata_i[`PDL_CTRL_LCNT_HI:`PDL_CTRL_LCNT_LO];
				end
				`PDL_ADDR_DIV:
				begin
					for (int k = 0; k < NUM_DIV; k++)
						div_reg[k*`PDL_DIV_STRIDE +: `PDL_DIV_W] <=
							(pwdata_i[k*`PDL_DIV_STRIDE +: `PDL_DIV_W] > `PDL_EXP_MAX)
							? `PDL_EXP_MAX : pwdata_i[k*`PDL_DIV_STRIDE +: `PDL_DIV_W];
				end
				`PDL_ADDR_SKEW:
				begin
					for (int k = 0; k <= NUM_DIV; k++)
						skew_reg[k*`PDL_SKEW_STRIDE +: `PDL_SKEW_W] <=
							pwdata_i[k*`PDL_SKEW_STRIDE +: `PDL_SKEW_W];
				end
				`PDL_ADDR_MASK: irq_mask <= pwdata_i[`PDL_IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Lock detector, counts matching reference cycles
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			lock_st <= pdl_pkg::PDL_UNLOCKED;
			lock_cnt <= 9'h000;
		end
		else if (ctrl.bypass)
		begin
			lock_st <= pdl_pkg::PDL_UNLOCKED;
			lock_cnt <= 9'h000;
		end
		else if (!match_sync[1])
		begin
			lock_st <= pdl_pkg::PDL_UNLOCKED;
			lock_cnt <= 9'h000;
		end
		else if (ref_rise)
		begin
			case (lock_st)
				pdl_pkg::PDL_UNLOCKED:
				begin
					lock_st <= pdl_pkg::PDL_COUNTING;
					lock_cnt <= 9'h001;
				end
				pdl_pkg::PDL_COUNTING:
				begin
					if (lock_cnt >= {1'b0, ctrl.lock_cnt} + 9'h001)
						lock_st <= pdl_pkg::PDL_LOCKED;
					else
						lock_cnt <= lock_cnt + 9'h001;
				end
				pdl_pkg::PDL_LOCKED: ;
				default: lock_st <= pdl_pkg::PDL_UNLOCKED;
			endcase
		end
	end

	// Lock output follows state, drop is combinationally early
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			lock_o <= 1'b0;
		else
			lock_o <= (lock_st == pdl_pkg::PDL_LOCKED) & match_sync[1] & ~ctrl.bypass;
	end

	// Divider source selection
	assign div_src = ctrl.bypass ? ref_sync[1] : vco_sync[1];
	assign skew_en = ~ctrl.bypass;

	for (genvar k = 0; k < NUM_DIV; k++)
	begin : g_div
		pdl_divider u_div (
			.clk_i(clk_i),
			.rst_b_i(rst_b_i),
			.exp_i(div_reg[k*`PDL_DIV_STRIDE +: `PDL_DIV_W]),
			.invert_i(ctrl.bypass),
			.src_i(div_src),
			.div_o(div_out[k])
		);
		pdl_skew u_skew (
			.clk_i(clk_i),
			.rst_b_i(rst_b_i),
			.step_i(skew_reg[k*`PDL_SKEW_STRIDE +: `PDL_SKEW_W]),
			.coarse_i(ctrl.coarse),
			.enable_i(skew_en),
			.src_i(div_out[k]),
			.skew_o(skew_out[k])
		);
	end

	// Feedback path with its own skew for both feedback sources, off in bypass
	pdl_skew u_fb_skew (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.step_i(skew_reg[NUM_DIV*`PDL_SKEW_STRIDE +: `PDL_SKEW_W]),
		.coarse_i(ctrl.coarse),
		.enable_i(skew_en),
		.src_i(ctrl.ext_fb ? efb_sync[1] : div_out[ctrl.fb_sel]),
		.skew_o(fb_int)
	);

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			clk_o <= '0;
			fb_o <= 1'b0;
		end
		else
		begin
			clk_o <= skew_out;
			fb_o <= fb_int;
		end
	end

	// Lock events, set wins over clear
	assign lock_rise = (lock_st != pdl_pkg::PDL_LOCKED) & ref_rise & match_sync[1]
		& ~ctrl.bypass & (lock_st == pdl_pkg::PDL_COUNTING)
		& (lock_cnt >= {1'b0, ctrl.lock_cnt} + 9'h001);
	assign lock_fall = (lock_st == pdl_pkg::PDL_LOCKED) & (~match_sync[1] | ctrl.bypass);

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			irq_stat <= '0;
		else
		begin
			for (int b = 0; b < `PDL_IRQ_W; b++)
			begin
				if ((b == `PDL_IRQ_LOCK && lock_rise) || (b == `PDL_IRQ_UNLOCK && lock_fall))
					irq_stat[b] <= 1'b1;
				else if (wr_en && pready_o && paddr_i == `PDL_ADDR_IRQ && pwdata_i[b])
					irq_stat[b] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(irq_stat & irq_mask);
	end

endmodule : pdl_top

// ==== verif/pdl_ref_model.sv ====
// Far side: reference and VCO levels, phase match, feedback loop.
// Levels change just after clk_i edges.
`timescale 1ns/1ps

module pdl_ref_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Bench controls
	input wire logic match_en_i,
	input wire logic loop_i,
	// Clock side
	output logic ref_o,
	output logic vco_o,
	output logic match_o,
	output logic fb_ext_o
);
	logic [3:0] cnt;
	// Reference 16 cycles, VCO 4 cycles
	assign ref_o = cnt[3];
	assign vco_o = cnt[1];
	always_ff @(posedge clk_i or negedge rst_b_i)
		if (!rst_b_i)
			cnt <= 4'h0;
		else
			cnt <= cnt + 4'h1;
	always_ff @(posedge clk_i)
	begin
		match_o <= match_en_i;
		fb_ext_o <= loop_i;
	end
endmodule : pdl_ref_model

// ==== verif/pdl_top_chk.sv ====
// Checker for the APB and lock behaviour of pdl_top.
// Sees top ports only; bound to every pdl_top below.
`timescale 1ns/1ps
`include "pdl_consts.svh"

module pdl_top_chk (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// APB
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// Lock
	input wire logic match_i,
	input wire logic lock_o
);
	logic acc;
	logic bad;
	logic byp_q;
	logic [7:0] run;
	assign acc = psel_i && penable_i && pready_o;
	assign bad = paddr_i > `PDL_ADDR_MASK || paddr_i[1:0] != 2'h0;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// Bypass bit as last written
	always_ff @(posedge clk_i or negedge rst_b_i)
		if (!rst_b_i)
			byp_q <= 1'b0;
		else if (acc && pwrite_i && paddr_i == `PDL_ADDR_CTRL)
			byp_q <= pwdata_i[`PDL_CTRL_BYPASS];
	// Consecutive match cycles, saturating
	always_ff @(posedge clk_i or negedge rst_b_i)
		if (!rst_b_i)
			run <= 8'h00;
		else
			run <= !match_i ? 8'h00 : run + {7'h00, run != 8'hFF};
	sequence s_steady;
		match_i [*4];
	endsequence
	a_ready_next: assert property (psel_i && !penable_i |=> pready_o)
		else $error("pready missing after setup");
	a_ready_once: assert property (pready_o |=> !pready_o)
		else $error("pready held too long");
	a_err_map: assert property (acc |-> pslverr_o == bad)
		else $error("pslverr wrong for address");
	a_rd_zero: assert property (acc && !pwrite_i && bad |-> prdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_lock_drop: assert property ($fell(match_i) |-> ##[1:4] !lock_o)
		else $error("lock kept after match lost");
	a_lock_nomatch: assert property (!match_i [*5] |-> !lock_o)
		else $error("lock without match");
	a_lock_wait: assert property ($rose(lock_o) |-> run >= 8'h10)
		else $error("lock raised too early");
	a_bypass_lock: assert property (byp_q && $past(byp_q, 4) |-> !lock_o)
		else $error("lock in bypass");
	a_lock_holds: assert property (s_steady ##0 (lock_o && !byp_q) |=> lock_o || byp_q)
		else $error("lock dropped while matching");
endmodule : pdl_top_chk

bind pdl_top pdl_top_chk u_chk (.clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
	.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .match_i, .lock_o);

// ==== verif/pdl_top_tb.sv ====
// Bench for pdl_top: APB tasks, lock timing, edge counts.
// Uses pdl_ref_model as clock source; checker is bound.
`timescale 1ns/1ps
`include "pdl_consts.svh"

module pdl_top_tb;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic men = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0;
	logic [31:0] rd;
	logic err;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic ref_c;
	logic vco_c;
	logic match_c;
	logic efb;
	logic [2:0] clko;
	logic fb;
	logic lock;
	logic irq;
	logic [4:0] prv = 5'h0;
	logic [3:0] rh = 4'h0;
	logic [3:0] hf = 4'h0;
	wire logic [4:0] sg = {ref_c, fb, clko};
	int ne [8];
	int t;
	int miscompares = 0;
	int n_checks = 0;
	logic [7:0] lc [2] = '{8'h0F, 8'hFF};
	// CTRL, DIV, SKEW, edges of clk_o[0..2] and fb_o per 512 cycles, skew counter
	int tab [6][8] = '{'{32'h0F10, 32'h0520, 32'h0000, 128, 32, 4, 32, 0},
		'{32'h0F01, 32'h0310, 32'h0003, 32, 16, 4, -1, 0},
		'{32'h0F20, 32'h0701, 32'h0000, 64, 128, 4, 4, 0},
		'{32'h0F02, 32'h0701, 32'h0000, 64, 128, 4, 64, 0},
		'{32'h0F14, 32'h0030, 32'h3050, 128, 16, 128, 16, 6},
		'{32'h0F10, 32'h0030, 32'h3050, 128, 16, 128, 16, 7}};

	always #12.5 clk_i = ~clk_i;

	pdl_ref_model u_ref (.clk_i(clk_i), .rst_b_i(rst_b_i), .match_en_i(men), .loop_i(clko[0]),
		.ref_o(ref_c), .vco_o(vco_c), .match_o(match_c), .fb_ext_o(efb));
	pdl_top u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .ref_i(ref_c), .vco_i(vco_c), .match_i(match_c), .ext_fb_i(efb),
		.clk_o(clko), .fb_o(fb), .lock_o(lock), .irq_o(irq));

	always @(posedge clk_i)
	begin
		prv <= sg;
		rh <= {rh[2:0], ref_c};
		hf <= {hf[2:0], fb};
		for (int i = 0; i < 5; i++)
			if (sg[i] && !prv[i])
				ne[i]++;
		// Bypassed ratio one lags the inverted reference by four samples
		if (clko[0] !== ~rh[3])
			ne[5]++;
		// clk_o[1] against fb_o: four samples behind in coarse, two in fine
		if (clko[1] !== hf[3])
			ne[6]++;
		if (clko[1] !== hf[1])
			ne[7]++;
	end

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		// Idle cycle between transfers
		@(posedge clk_i);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk_i);
		pen <= 1'b1;
		do @(posedge clk_i); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task chkn(input string n, input int e, input int s);
		n_checks++;
		if (s < e - 1 || s > e + 1)
		begin
			miscompares++;
			$display("BAD %s expected %0d seen %0d", n, e, s);
		end
	endtask : chkn

	task complete_run;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	initial
	begin
		#(30000 * 25);
		miscompares++;
		complete_run();
	end

	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		apb(1'b0, `PDL_ADDR_CTRL, 32'h0);
		chk("ctrl reset", 32'h0000_0F00, rd);
		apb(1'b1, `PDL_ADDR_CTRL, 32'h0);
		apb(1'b0, `PDL_ADDR_CTRL, 32'h0);
		chk("lock count floor", 32'h0000_0F00, rd);
		apb(1'b0, 12'h018, 32'h0);
		chk("unmapped data", 32'h0, rd);
		chk("unmapped err", 32'h1, {31'h0, err});
		foreach (lc[i])
		begin
			men <= 1'b0;
			apb(1'b1, `PDL_ADDR_CTRL, {16'h0, lc[i], 8'h00});
			apb(1'b1, `PDL_ADDR_IRQ, 32'h3);
			repeat (8) @(posedge clk_i);
			men <= 1'b1;
			ne[4] = 0;
			for (t = 0; t < 6000 && lock !== 1'b1; t++)
				@(posedge clk_i);
			chkn("lock ref count", lc[i] + 2, ne[4]);
			apb(1'b0, `PDL_ADDR_STAT, 32'h0);
			chk("stat locked", 32'h2, rd);
			men <= 1'b0;
			repeat (6) @(posedge clk_i);
			chk("lock lost", 32'h0, {31'h0, lock});
			apb(1'b0, `PDL_ADDR_IRQ, 32'h0);
			chk("irq status", 32'h3, rd);
		end
		apb(1'b1, `PDL_ADDR_MASK, 32'h1);
		repeat (2) @(posedge clk_i);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		apb(1'b1, `PDL_ADDR_IRQ, 32'h1);
		repeat (2) @(posedge clk_i);
		chk("irq cleared", 32'h0, {31'h0, irq});
		men <= 1'b1;
		for (int c = 0; c < 6; c++)
		begin
			apb(1'b1, `PDL_ADDR_CTRL, tab[c][0]);
			apb(1'b1, `PDL_ADDR_DIV, tab[c][1]);
			apb(1'b1, `PDL_ADDR_SKEW, tab[c][2]);
			repeat (64) @(posedge clk_i);
			ne = '{default: 0};
			repeat (512) @(posedge clk_i);
			for (int k = 0; k < 3; k++)
				chkn("divider edges", tab[c][k + 3], ne[k]);
			if (tab[c][6] >= 0)
				chkn("feedback edges", tab[c][6], ne[3]);
			else
			begin
				chk("bypass inverted", 32'h0, ne[5]);
				chk("bypass no lock", 32'h0, {31'h0, lock});
			end
			if (tab[c][7] > 0)
				chk("skew delay", 32'h0, ne[tab[c][7]]);
		end
		complete_run();
	end
endmodule : pdl_top_tb
